// ===== core/fabe_pkg.sv
package fabe_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int PORT_COUNT = 3;

    // ----------------------------------------
    // Instruction word fields
    // ----------------------------------------
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int NIB_HI = 11;
    localparam int NIB_LO = 8;
    localparam int SUB_HI = 11;
    localparam int SUB_LO = 10;
    localparam int DEST_POS = 7;
    localparam int BIT_HI = 9;
    localparam int BIT_LO = 7;
    localparam int FILE_HI = 6;
    localparam int FILE_LO = 0;
    localparam int NIBBLE_CARRY_POS = 4;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [3:0] NIB_ADD = 4'h7;
    localparam logic [3:0] NIB_AND = 4'h5;
    localparam logic [1:0] SUB_BCLR = 2'h0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ----------------------------------------
    // Special file addresses
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] TIMER_ZERO_COUNT_ADDR = 7'h01;
    localparam logic [PORT_COUNT-1:0][ADDR_W-1:0] PORT_ADDR = {7'h07, 7'h06, 7'h05};

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [1:0] {
        FABE_OP_NONE,
        FABE_OP_SUM,
        FABE_OP_MASK,
        FABE_OP_CLEAR
    } fabe_op_e;

endpackage : fabe_pkg

// ===== core/fabe_alu_if.sv
interface fabe_alu_if;
    import fabe_pkg::*;

    fabe_op_e op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] operand;
    logic [BIT_W-1:0] bit_sel;
    logic [DATA_W-1:0] result;
    logic carry;
    logic dcarry;
    logic zero;

    modport ctrl (output op, output acc, output operand, output bit_sel,
                  input result, input carry, input dcarry, input zero);
    modport unit (input op, input acc, input operand, input bit_sel,
                  output result, output carry, output dcarry, output zero);
endinterface : fabe_alu_if

// ===== core/fabe_alu.sv
module fabe_alu (
    fabe_alu_if.unit alu
);
    import fabe_pkg::*;

    logic [DATA_W:0] sum;
    logic [NIBBLE_CARRY_POS:0] low_sum;

    always_comb begin
        sum = {1'b0, alu.acc} + {1'b0, alu.operand};
        low_sum = {1'b0, alu.acc[3:0]} + {1'b0, alu.operand[3:0]};
        alu.result = alu.operand;
        alu.carry = 1'b0;
        alu.dcarry = 1'b0;
        unique case (alu.op)
            FABE_OP_SUM: begin
                alu.result = sum[DATA_W-1:0];
                // carries from bits 7 and 3
                alu.carry = sum[DATA_W];
                alu.dcarry = low_sum[NIBBLE_CARRY_POS];
            end
            FABE_OP_MASK: begin
                alu.result = alu.acc & alu.operand;
            end
            FABE_OP_CLEAR: begin
                alu.result = alu.operand & ~(8'h01 << alu.bit_sel);
            end
            FABE_OP_NONE: begin
                alu.result = alu.operand;
            end
        endcase
        alu.zero = (alu.result == 8'h00);
    end

endmodule : fabe_alu

// ===== core/fabe_exec.sv
module fabe_exec (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic instr_valid_i,
    input wire logic [fabe_pkg::INSTR_W-1:0] instr_i,
    input wire logic [fabe_pkg::DATA_W-1:0] rd_data_i,
    input wire logic [fabe_pkg::PORT_COUNT-1:0][fabe_pkg::DATA_W-1:0] pin_level_i,
    input wire logic prescaler_assigned_i,
    output logic [fabe_pkg::ADDR_W-1:0] rd_addr_o,
    output logic rd_en_o,
    output logic [fabe_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [fabe_pkg::DATA_W-1:0] wr_data_o,
    output logic wr_en_o,
    output logic [fabe_pkg::DATA_W-1:0] acc_o,
    output logic carry_o,
    output logic dcarry_o,
    output logic zero_o,
    output logic prescaler_clear_o,
    output logic done_o,
    output logic unsupported_o
);
    import fabe_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic fabe_op_e decode_op(input logic [INSTR_W-1:0] w);
        fabe_op_e op;
        op = FABE_OP_NONE;
        if (w[CLASS_HI:CLASS_LO] == CLASS_BYTE && w[NIB_HI:NIB_LO] == NIB_ADD) begin
            op = FABE_OP_SUM;
        end else if (w[CLASS_HI:CLASS_LO] == CLASS_BYTE && w[NIB_HI:NIB_LO] == NIB_AND) begin
            op = FABE_OP_MASK;
        end else if (w[CLASS_HI:CLASS_LO] == CLASS_BIT && w[SUB_HI:SUB_LO] == SUB_BCLR) begin
            op = FABE_OP_CLEAR;
        end
        return op;
    endfunction : decode_op

    function automatic logic writes_file(input fabe_op_e op, input logic dest);
        return (op == FABE_OP_CLEAR) || ((op != FABE_OP_NONE) && dest == DEST_FILE);
    endfunction : writes_file

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic [PORT_COUNT-1:0][DATA_W-1:0] pin_meta_q;
    logic [PORT_COUNT-1:0][DATA_W-1:0] pin_sync_q;

    genvar gp;
    generate
        for (gp = 0; gp < PORT_COUNT; gp++) begin : g_pin_sync
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    pin_meta_q[gp] <= 8'h00;
                    pin_sync_q[gp] <= 8'h00;
                end else begin
                    pin_meta_q[gp] <= pin_level_i[gp];
                    pin_sync_q[gp] <= pin_meta_q[gp];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Phase sequencer and datapath
    // ----------------------------------------
    typedef enum logic [2:0] {
        FABE_PH_IDLE,
        FABE_PH_DECODE,
        FABE_PH_READ,
        FABE_PH_PROCESS,
        FABE_PH_WRITE
    } fabe_phase_e;

    fabe_phase_e phase_q, phase_d;
    logic [INSTR_W-1:0] instr_q, instr_d;
    fabe_op_e op_q, op_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic rd_en_q, rd_en_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [DATA_W-1:0] wr_data_q, wr_data_d;
    logic wr_en_q, wr_en_d;
    logic [DATA_W-1:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic dcarry_q, dcarry_d;
    logic zero_q, zero_d;
    logic psc_clr_q, psc_clr_d;
    logic done_q, done_d;
    logic unsup_q, unsup_d;
    logic [DATA_W-1:0] operand;
    logic take;

    fabe_alu_if alu_bus ();

    fabe_alu u_alu (
        .alu(alu_bus.unit)
    );

    always_comb begin
        operand = rd_data_i;
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (instr_q[FILE_HI:FILE_LO] == PORT_ADDR[i]) begin
                operand = pin_sync_q[i];
            end
        end
        alu_bus.op = op_q;
        alu_bus.acc = acc_q;
        alu_bus.operand = operand;
        alu_bus.bit_sel = instr_q[BIT_HI:BIT_LO];
    end

    always_comb begin
        take = instr_valid_i && (phase_q == FABE_PH_IDLE || phase_q == FABE_PH_WRITE);
        phase_d = phase_q;
        instr_d = instr_q;
        op_d = op_q;
        rd_addr_d = rd_addr_q;
        rd_en_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        wr_en_d = 1'b0;
        acc_d = acc_q;
        carry_d = carry_q;
        dcarry_d = dcarry_q;
        zero_d = zero_q;
        psc_clr_d = 1'b0;
        done_d = 1'b0;
        unsup_d = 1'b0;
        unique case (phase_q)
            FABE_PH_IDLE, FABE_PH_WRITE: begin
                phase_d = take ? FABE_PH_DECODE : FABE_PH_IDLE;
                if (take) begin
                    instr_d = instr_i;
                end
            end
            FABE_PH_DECODE: begin
                phase_d = FABE_PH_READ;
                op_d = decode_op(instr_q);
                unsup_d = (decode_op(instr_q) == FABE_OP_NONE);
                rd_addr_d = instr_q[FILE_HI:FILE_LO];
                rd_en_d = (decode_op(instr_q) != FABE_OP_NONE);
            end
            FABE_PH_READ: begin
                phase_d = FABE_PH_PROCESS;
            end
            FABE_PH_PROCESS: begin
                phase_d = FABE_PH_WRITE;
                done_d = 1'b1;
                if (writes_file(op_q, instr_q[DEST_POS])) begin
                    wr_en_d = 1'b1;
                    wr_addr_d = instr_q[FILE_HI:FILE_LO];
                    wr_data_d = alu_bus.result;
                    psc_clr_d = prescaler_assigned_i && (instr_q[FILE_HI:FILE_LO] == TIMER_ZERO_COUNT_ADDR);
                end else if (op_q != FABE_OP_NONE) begin
                    acc_d = alu_bus.result;
                end
                if (op_q == FABE_OP_SUM) begin
                    carry_d = alu_bus.carry;
                    dcarry_d = alu_bus.dcarry;
                end
                if (op_q == FABE_OP_SUM || op_q == FABE_OP_MASK) begin
                    zero_d = alu_bus.zero;
                end
            end
            default: begin
                phase_d = FABE_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q <= FABE_PH_IDLE;
            instr_q <= 14'h0000;
            op_q <= FABE_OP_NONE;
            rd_addr_q <= 7'h00;
            rd_en_q <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
            wr_en_q <= 1'b0;
            acc_q <= ACC_RESET;
            carry_q <= FLAG_RESET;
            dcarry_q <= FLAG_RESET;
            zero_q <= FLAG_RESET;
            psc_clr_q <= 1'b0;
            done_q <= 1'b0;
            unsup_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            instr_q <= instr_d;
            op_q <= op_d;
            rd_addr_q <= rd_addr_d;
            rd_en_q <= rd_en_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            wr_en_q <= wr_en_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            dcarry_q <= dcarry_d;
            zero_q <= zero_d;
            psc_clr_q <= psc_clr_d;
            done_q <= done_d;
            unsup_q <= unsup_d;
        end
    end

    assign rd_addr_o = rd_addr_q;
    assign rd_en_o = rd_en_q;
    assign wr_addr_o = wr_addr_q;
    assign wr_data_o = wr_data_q;
    assign wr_en_o = wr_en_q;
    assign acc_o = acc_q;
    assign carry_o = carry_q;
    assign dcarry_o = dcarry_q;
    assign zero_o = zero_q;
    assign prescaler_clear_o = psc_clr_q;
    assign done_o = done_q;
    assign unsupported_o = unsup_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_taken;
        take;
    endsequence

    sequence s_phases;
        phase_q == FABE_PH_DECODE ##1 phase_q == FABE_PH_READ ##1 phase_q == FABE_PH_PROCESS
            ##1 phase_q == FABE_PH_WRITE;
    endsequence

    phase_walk_a: assert property (s_taken |=> s_phases) else $error("phase walk broken");
    done_timing_a: assert property (done_o |-> $past(phase_q) == FABE_PH_PROCESS && phase_q == FABE_PH_WRITE)
        else $error("done out of phase");
    read_index_a: assert property (rd_en_o |-> rd_addr_o == instr_q[FILE_HI:FILE_LO] && phase_q == FABE_PH_READ)
        else $error("read index wrong");
    sum_acc_a: assert property (phase_q == FABE_PH_PROCESS && op_q == FABE_OP_SUM && instr_q[DEST_POS] == DEST_ACC
        |=> acc_o == $past(acc_q) + $past(operand)) else $error("sum to accumulator wrong");
    sum_flags_a: assert property (phase_q == FABE_PH_PROCESS && op_q == FABE_OP_SUM
        |=> carry_o == (({1'b0, $past(acc_q)} + {1'b0, $past(operand)}) > 9'h0FF)
            && dcarry_o == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(operand[3:0])}) > 5'h0F))
        else $error("carry flags wrong");
    mask_flags_a: assert property (phase_q == FABE_PH_PROCESS && op_q == FABE_OP_MASK
        |=> $stable(carry_o) && $stable(dcarry_o) && zero_o == ($past(acc_q & operand) == 8'h00))
        else $error("mask flags wrong");
    file_write_a: assert property (phase_q == FABE_PH_PROCESS && op_q == FABE_OP_MASK && instr_q[DEST_POS] == DEST_FILE
        |=> wr_en_o && wr_data_o == $past(acc_q & operand) && $stable(acc_o)) else $error("file target wrong");
    bit_clear_a: assert property (phase_q == FABE_PH_PROCESS && op_q == FABE_OP_CLEAR
        |=> wr_en_o && wr_data_o == ($past(operand) & ~(8'h01 << $past(instr_q[BIT_HI:BIT_LO])))
            && $stable(zero_o) && $stable(carry_o) && $stable(acc_o)) else $error("bit clear wrong");
    prescaler_clear_a: assert property (prescaler_clear_o |-> wr_en_o && wr_addr_o == TIMER_ZERO_COUNT_ADDR
        ##1 !prescaler_clear_o) else $error("prescaler clear wrong");
    port_pins_a: assert property (phase_q == FABE_PH_PROCESS && instr_q[FILE_HI:FILE_LO] == PORT_ADDR[0]
        |-> operand == pin_sync_q[0]) else $error("port read not from pins");

endmodule : fabe_exec

// ===== testbench/fabe_mem_model.sv
module fabe_mem_model (
    input wire logic clock_i,
    input wire logic rd_en_i,
    input wire logic [fabe_pkg::ADDR_W-1:0] rd_addr_i,
    input wire logic wr_en_i,
    input wire logic [fabe_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [fabe_pkg::DATA_W-1:0] wr_data_i,
    output logic [fabe_pkg::DATA_W-1:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import fabe_pkg::*;

    // ----------------------------------------
    // File register array
    // ----------------------------------------
    // seven-bit index
    logic [DATA_W-1:0] mem [0:127];

    task automatic poke(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        mem[a] = d;
    endtask : poke

    initial rd_data_o = 8'h00;

    always @(posedge clock_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end else begin
            rd_data_o <= ~rd_data_o;
        end
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end
endmodule : fabe_mem_model

// ===== testbench/fabe_exec_tb.sv
module fabe_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fabe_pkg::*;

    logic clock_i, reset_i, instr_valid_i, prescaler_assigned_i;
    logic [INSTR_W-1:0] instr_i;
    logic [DATA_W-1:0] rd_data_i, wr_data_o, acc_o, acc_e;
    logic [PORT_COUNT-1:0][DATA_W-1:0] pin_level_i;
    logic [ADDR_W-1:0] rd_addr_o, wr_addr_o;
    logic rd_en_o, wr_en_o, carry_o, dcarry_o, zero_o, prescaler_clear_o, done_o, unsupported_o;
    logic c_e, dc_e, z_e;
    logic [DATA_W-1:0] shadow [0:127];
    int err_count, n_tests;

    fabe_exec dut (.clock_i(clock_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .rd_data_i(rd_data_i), .pin_level_i(pin_level_i), .prescaler_assigned_i(prescaler_assigned_i),
        .rd_addr_o(rd_addr_o), .rd_en_o(rd_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .wr_en_o(wr_en_o), .acc_o(acc_o), .carry_o(carry_o), .dcarry_o(dcarry_o), .zero_o(zero_o),
        .prescaler_clear_o(prescaler_clear_o), .done_o(done_o), .unsupported_o(unsupported_o));

    fabe_mem_model u_mem (.clock_i(clock_i), .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o), .wr_en_i(wr_en_o),
        .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .rd_data_o(rd_data_i));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [INSTR_W-1:0] sum_into_target(input logic [6:0] f, input logic d);
        return {CLASS_BYTE, NIB_ADD, d, f};
    endfunction : sum_into_target

    function automatic logic [INSTR_W-1:0] mask_into_target(input logic [6:0] f, input logic d);
        return {CLASS_BYTE, NIB_AND, d, f};
    endfunction : mask_into_target

    function automatic logic [INSTR_W-1:0] single_position_clear(input logic [6:0] f, input logic [2:0] b);
        return {CLASS_BIT, SUB_BCLR, b, f};
    endfunction : single_position_clear

    function automatic logic [DATA_W-1:0] operand(input logic [ADDR_W-1:0] f);
        operand = shadow[f];
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (f == PORT_ADDR[i]) operand = pin_level_i[i];
        end
    endfunction : operand

    task automatic set_mem(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        shadow[a] = d;
        u_mem.poke(a, d);
    endtask : set_mem

    task automatic issue(input logic [INSTR_W-1:0] w);
        instr_valid_i = 1'b1;
        instr_i = w;
        @(posedge clock_i);
        #1;
        instr_valid_i = 1'b0;
    endtask : issue

    // ----------------------------------------
    // One supported word, predicted and checked
    // ----------------------------------------
    task automatic run_op(input logic [INSTR_W-1:0] w);
        logic [ADDR_W-1:0] f;
        logic [DATA_W-1:0] v, r;
        logic [8:0] s;
        logic [ADDR_W-1:0] ra;
        logic wb, pa, us;
        int k;
        int rd_seen;
        f = w[FILE_HI:FILE_LO];
        v = operand(f);
        pa = prescaler_assigned_i;
        r = v;
        wb = 1'b1;
        if (w[CLASS_HI:CLASS_LO] == CLASS_BYTE && w[NIB_HI:NIB_LO] == NIB_ADD) begin
            s = acc_e + v;
            r = s[7:0];
            c_e = s[8];
            dc_e = ({1'b0, acc_e[3:0]} + {1'b0, v[3:0]}) > 5'h0F;
            z_e = (r == 8'h00);
            wb = w[DEST_POS];
        end else if (w[CLASS_HI:CLASS_LO] == CLASS_BYTE) begin
            r = acc_e & v;
            z_e = (r == 8'h00);
            wb = w[DEST_POS];
        end else begin
            r[w[BIT_HI:BIT_LO]] = 1'b0;
        end
        issue(w);
        k = 0;
        rd_seen = 0;
        ra = '0;
        us = 1'b0;
        while (done_o !== 1'b1 && k < 8) begin
            @(posedge clock_i);
            #1;
            k++;
            if (rd_en_o === 1'b1) begin
                rd_seen++;
                ra = rd_addr_o;
            end
            us |= (unsupported_o !== 1'b0);
        end
        check("done", done_o, 8'h01);
        check("cycles to done", 8'(k), 8'h03);
        check("read strobes", 8'(rd_seen), 8'h01);
        check("read index", ra, f);
        check("unsupported on good word", us, 8'h00);
        check("write strobe", wr_en_o, wb);
        if (wb) begin
            check("write index", wr_addr_o, f);
            check("write data", wr_data_o, r);
            shadow[f] = r;
        end else begin
            acc_e = r;
        end
        check("acc", acc_o, acc_e);
        check("carry", carry_o, c_e);
        check("digit carry", dcarry_o, dc_e);
        check("zero", zero_o, z_e);
        check("prescaler clear", prescaler_clear_o, wb && f == TIMER_ZERO_COUNT_ADDR && pa);
    endtask : run_op

    task automatic bad_op(input logic [INSTR_W-1:0] w);
        logic seen_u, seen_w;
        seen_u = 1'b0;
        seen_w = 1'b0;
        issue(w);
        repeat (6) begin
            seen_u |= (unsupported_o === 1'b1);
            seen_w |= (wr_en_o !== 1'b0);
            @(posedge clock_i);
            #1;
        end
        check("unsupported", seen_u, 8'h01);
        check("no write", seen_w, 8'h00);
        check("acc kept", acc_o, acc_e);
        check("flags kept", {carry_o, dcarry_o, zero_o}, {c_e, dc_e, z_e});
    endtask : bad_op

    // ----------------------------------------
    // Clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial begin
        #50000;
        err_count++;
        report_and_stop();
    end

    initial begin
        reset_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = '0;
        prescaler_assigned_i = 1'b0;
        err_count = 0;
        n_tests = 0;
        {acc_e, c_e, dc_e, z_e} = '0;
        void'($urandom(31));
        pin_level_i = 24'($urandom);
        for (int i = 0; i < 128; i++) set_mem(7'(i), 8'($urandom));
        repeat (4) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        check("reset acc", acc_o, ACC_RESET);
        check("reset flags", {carry_o, dcarry_o, zero_o}, 8'h00);
        set_mem(7'h20, 8'hFF);
        set_mem(7'h21, 8'h01);
        set_mem(7'h30, 8'hC7);
        run_op(sum_into_target(7'h20, 1'b0));
        run_op(sum_into_target(7'h21, 1'b1));
        run_op(mask_into_target(7'h30, 1'b1));
        run_op(single_position_clear(7'h30, 3'd7));
        run_op(single_position_clear(7'h7F, 3'd0));
        prescaler_assigned_i = 1'b1;
        run_op(sum_into_target(TIMER_ZERO_COUNT_ADDR, 1'b1));
        run_op(single_position_clear(TIMER_ZERO_COUNT_ADDR, 3'd2));
        run_op(mask_into_target(TIMER_ZERO_COUNT_ADDR, 1'b0));
        prescaler_assigned_i = 1'b0;
        run_op(sum_into_target(TIMER_ZERO_COUNT_ADDR, 1'b1));
        for (int i = 0; i < PORT_COUNT; i++) begin
            run_op(single_position_clear(PORT_ADDR[i], 3'(i)));
            run_op(sum_into_target(PORT_ADDR[i], 1'b1));
            run_op(mask_into_target(PORT_ADDR[i], 1'b0));
        end
        bad_op(14'h3FFF);
        bad_op({CLASS_BYTE, 4'h6, 8'h12});
        bad_op({CLASS_BIT, 2'h1, 10'h012});
        reset_i = 1'b1;
        @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        {acc_e, c_e, dc_e, z_e} = '0;
        check("second reset acc", acc_o, ACC_RESET);
        check("second reset flags", {carry_o, dcarry_o, zero_o}, 8'h00);
        pin_level_i = 24'($urandom);
        repeat (3) @(posedge clock_i);
        #1;
        repeat (90) begin
            prescaler_assigned_i = 1'($urandom);
            case ($urandom % 3)
                0: run_op(sum_into_target(7'($urandom), 1'($urandom)));
                1: run_op(mask_into_target(7'($urandom), 1'($urandom)));
                default: run_op(single_position_clear(7'($urandom), 3'($urandom)));
            endcase
        end
        report_and_stop();
    end
endmodule : fabe_exec_tb
